// ---- rtl/blcfg_cfg.svh ----
`ifndef BLCFG_CFG_SVH
`define BLCFG_CFG_SVH
`define BLCFG_ADDR_LO 7'h36
`define BLCFG_ADDR_HI 7'h37
`define BLCFG_REG_REV 8'h00
`define BLCFG_REG_SRST 8'h01
`define BLCFG_REG_EN 8'h10
`define BLCFG_REG_BRC 8'h11
`define BLCFG_REG_PWM 8'h12
`define BLCFG_REG_BST 8'h13
`define BLCFG_REG_AFH 8'h15
`define BLCFG_REG_AFL 8'h16
`define BLCFG_REG_BLSB 8'h18
`define BLCFG_REG_BMSB 8'h19
`define BLCFG_REG_FCTL 8'h1E
`define BLCFG_REG_FFLG 8'h1F
`define BLCFG_RST_EN 4'hF
`define BLCFG_RST_BRC 8'h60
`define BLCFG_RST_PWM 8'hF3
`define BLCFG_RST_BST 7'h6F
`define BLCFG_RST_AF 8'h00
`define BLCFG_RST_BLSB 3'h7
`define BLCFG_RST_BMSB 8'hFF
`define BLCFG_RST_FCTL 4'h7
`define BLCFG_FB_OVP 0
`define BLCFG_FB_OCP 1
`define BLCFG_FB_TSD 2
`define BLCFG_FB_SHORT 3
`define BLCFG_FB_OPEN 4
`endif

// ---- rtl/blcfg_pkg.sv ----
package blcfg_pkg;
  typedef enum logic [2:0] {
    BLCFG_IDLE, BLCFG_ADDR, BLCFG_REGIDX, BLCFG_WDATA, BLCFG_RDATA
  } blcfg_state_e;
  typedef logic [7:0] blcfg_byte_t;
endpackage

// ---- rtl/blcfg_sync2.sv ----
`timescale 1ns/1ps
module blcfg_sync2 #(
  parameter logic IDLE_LVL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;
  logic hold_ff;
  always_ff @(posedge sys_clk) begin
    // reset to the pin's idle level, else a false event follows reset
    if (sys_rst) begin
      meta_ff <= IDLE_LVL;
      hold_ff <= IDLE_LVL;
    end else begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end
  assign sync_out = hold_ff;
endmodule

// ---- rtl/blcfg_top.sv ----
`timescale 1ns/1ps
`include "blcfg_cfg.svh"
module blcfg_top
#(
  parameter logic [3:0] REV_CODE = 4'h1  // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic address_select_pin,
  input wire logic overcurrent_limit,
  input wire logic thermal_shutdown,
  input wire logic thermal_cool,
  input wire logic overvoltage_limit,
  input wire logic string_open_evt,
  input wire logic string_short_evt,
  output logic device_active,
  output logic boost_switch_en,
  output logic [2:0] string_on,
  output logic [7:0] brightness_ctrl,
  output logic [7:0] pwm_ctrl,
  output logic [6:0] boost_cfg,
  output logic [7:0] autofreq_high,
  output logic [7:0] autofreq_low,
  output logic [10:0] brightness_code,
  output logic short_detect_en
);
  import blcfg_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic scl_s;
  logic sda_s;
  logic ocl_s;
  logic tsd_s;
  logic cool_s;
  logic ovl_s;
  logic opn_s;
  logic sht_s;
  blcfg_sync2 u_scl (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(scl_in), .sync_out(scl_s));
  blcfg_sync2 u_sda (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(sda_in), .sync_out(sda_s));
  blcfg_sync2 #(.IDLE_LVL(1'b0)) u_ocl (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(overcurrent_limit), .sync_out(ocl_s));
  blcfg_sync2 #(.IDLE_LVL(1'b0)) u_tsd (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(thermal_shutdown), .sync_out(tsd_s));
  blcfg_sync2 #(.IDLE_LVL(1'b0)) u_cool (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(thermal_cool), .sync_out(cool_s));
  blcfg_sync2 #(.IDLE_LVL(1'b0)) u_ovl (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(overvoltage_limit), .sync_out(ovl_s));
  blcfg_sync2 #(.IDLE_LVL(1'b0)) u_opn (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(string_open_evt), .sync_out(opn_s));
  blcfg_sync2 #(.IDLE_LVL(1'b0)) u_sht (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(string_short_evt), .sync_out(sht_s));
  ////////////////////////////////////////////////////////////////////////
  logic scl_d_ff;
  logic sda_d_ff;
  logic address_select_pin_ff;
  logic address_select_pin_meta_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end
  // static strap, still synced: it is a pin like any other
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      address_select_pin_meta_ff <= 1'b0;
      address_select_pin_ff <= 1'b0;
    end else begin
      address_select_pin_meta_ff <= address_select_pin;
      address_select_pin_ff <= address_select_pin_meta_ff;
    end
  end
  wire scl_rise = scl_s && !scl_d_ff;
  wire scl_fall = !scl_s && scl_d_ff;
  wire start_cond = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  wire stop_cond = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  wire [6:0] my_addr = address_select_pin_ff ? `BLCFG_ADDR_HI : `BLCFG_ADDR_LO;
  ////////////////////////////////////////////////////////////////////////
  blcfg_state_e state_ff;
  blcfg_state_e nxt_state;
  logic busy_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] index_ff;
  logic ack_phase_ff;
  logic ack_ok_ff;
  logic sda_drv_ff;
  logic rnw_ff;
  logic [7:0] tx_ff;
  logic master_nak_ff;
  wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
  wire byte_done = scl_rise && (bit_cnt_ff == 4'd7) && !ack_phase_ff;
  wire addr_hit = rx_byte[7:1] == my_addr;
  wire wr_strobe = byte_done && state_ff == BLCFG_WDATA;
  wire flag_read = scl_rise && ack_phase_ff && state_ff == BLCFG_RDATA
    && rnw_ff && index_ff == `BLCFG_REG_FFLG;
  logic [7:0] rd_data;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BLCFG_IDLE: nxt_state = BLCFG_IDLE;
      BLCFG_ADDR: begin
        if (byte_done) begin
          if (!addr_hit) begin
            nxt_state = BLCFG_IDLE;
          end else if (rx_byte[0]) begin
            nxt_state = BLCFG_RDATA;
          end else begin
            nxt_state = BLCFG_REGIDX;
          end
        end
      end
      BLCFG_REGIDX: if (byte_done) nxt_state = BLCFG_WDATA;
      BLCFG_WDATA: nxt_state = BLCFG_WDATA;
      BLCFG_RDATA: begin
        if (master_nak_ff) nxt_state = BLCFG_IDLE;
      end
      default: nxt_state = BLCFG_IDLE;
    endcase
    if (start_cond) nxt_state = BLCFG_ADDR;
    if (stop_cond) nxt_state = BLCFG_IDLE;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= BLCFG_IDLE;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start_cond) busy_ff <= 1'b1;
      else if (stop_cond) busy_ff <= 1'b0;
    end
  end
  // bit counter and shifter, msb first
  always_ff @(posedge sys_clk) begin
    if (sys_rst || start_cond) begin
      bit_cnt_ff <= 4'd0;
      shift_ff <= 8'h00;
      ack_phase_ff <= 1'b0;
      master_nak_ff <= 1'b0;
    end else if (scl_rise && state_ff != BLCFG_IDLE) begin
      if (ack_phase_ff) begin
        ack_phase_ff <= 1'b0;
        bit_cnt_ff <= 4'd0;
        master_nak_ff <= (state_ff == BLCFG_RDATA) && sda_s;
      end else begin
        shift_ff <= rx_byte;
        if (bit_cnt_ff == 4'd7) ack_phase_ff <= 1'b1;
        else bit_cnt_ff <= bit_cnt_ff + 4'd1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      index_ff <= 8'h00;
      ack_ok_ff <= 1'b0;
    end else if (byte_done) begin
      ack_ok_ff <= (state_ff != BLCFG_ADDR) || addr_hit;
      if (state_ff == BLCFG_REGIDX) index_ff <= rx_byte;
    end
  end
  // sda only changes on scl low to keep start/stop clean
  always_ff @(posedge sys_clk) begin
    if (sys_rst || stop_cond || start_cond) begin
      sda_drv_ff <= 1'b0;
      tx_ff <= 8'h00;
      rnw_ff <= 1'b0;
    end else if (scl_fall) begin
      if (ack_phase_ff && ack_ok_ff && !rnw_ff) begin
        sda_drv_ff <= 1'b1;
      end else if (!ack_phase_ff && state_ff == BLCFG_RDATA
          && !rnw_ff) begin
        rnw_ff <= 1'b1;
        sda_drv_ff <= !rd_data[7];
        tx_ff <= {rd_data[6:0], 1'b0};
      end else if (rnw_ff && state_ff == BLCFG_RDATA && !ack_phase_ff
          && !master_nak_ff) begin
        sda_drv_ff <= !tx_ff[7];
        tx_ff <= {tx_ff[6:0], 1'b0};
      end else begin
        sda_drv_ff <= 1'b0;
      end
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_n = !sda_drv_ff;
  ////////////////////////////////////////////////////////////////////////
  logic [3:0] en_ff;
  logic [7:0] brc_ff;
  logic [7:0] pwm_ff;
  logic [6:0] bst_ff;
  logic [7:0] afh_ff;
  logic [7:0] afl_ff;
  logic [2:0] blsb_ff;
  logic [7:0] bmsb_ff;
  logic [3:0] fctl_ff;
  logic [4:0] flags_ff;
  logic srst_ff;
  logic latch_ff;
  logic boost_hold_ff;
  wire sw_rst = srst_ff;
  wire wr_en = wr_strobe && index_ff == `BLCFG_REG_EN;
  wire ocp_sd = !fctl_ff[`BLCFG_FB_OCP] && flags_ff[`BLCFG_FB_OCP];
  wire tsd_sd = !fctl_ff[`BLCFG_FB_TSD] && flags_ff[`BLCFG_FB_TSD];
  wire ovp_sd = !fctl_ff[`BLCFG_FB_OVP] && flags_ff[`BLCFG_FB_OVP];
  wire [4:0] flag_set = {opn_s, sht_s && fctl_ff[3], tsd_s, ocl_s, ovl_s};
  wire sd_evt = |(~fctl_ff[2:0] & {tsd_s, ocl_s, ovl_s});
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      srst_ff <= 1'b0;
    end else begin
      srst_ff <= wr_strobe && index_ff == `BLCFG_REG_SRST
        && rx_byte[0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || sw_rst) begin
      en_ff <= `BLCFG_RST_EN;
      brc_ff <= `BLCFG_RST_BRC;
      pwm_ff <= `BLCFG_RST_PWM;
      bst_ff <= `BLCFG_RST_BST;
      afh_ff <= `BLCFG_RST_AF;
      afl_ff <= `BLCFG_RST_AF;
      blsb_ff <= `BLCFG_RST_BLSB;
      bmsb_ff <= `BLCFG_RST_BMSB;
      fctl_ff <= `BLCFG_RST_FCTL;
    end else if (wr_strobe) begin
      case (index_ff)
        `BLCFG_REG_EN: begin
          // re-enable refused while a latched shutdown waits
          en_ff[3:1] <= rx_byte[3:1];
          en_ff[0] <= rx_byte[0] && !latch_ff;
        end
        `BLCFG_REG_BRC: brc_ff <= {rx_byte[7:1], 1'b0};
        `BLCFG_REG_PWM: pwm_ff <= rx_byte;
        `BLCFG_REG_BST: bst_ff <= rx_byte[6:0];
        `BLCFG_REG_AFH: afh_ff <= rx_byte;
        `BLCFG_REG_AFL: afl_ff <= rx_byte;
        `BLCFG_REG_BLSB: blsb_ff <= rx_byte[2:0];
        `BLCFG_REG_BMSB: bmsb_ff <= rx_byte;
        `BLCFG_REG_FCTL: fctl_ff <= rx_byte[3:0];
        default: en_ff <= en_ff;
      endcase
    end else if (ocp_sd || tsd_sd || ovp_sd) begin
      en_ff[0] <= 1'b0;
    end
  end
  // set wins over the read-clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst || sw_rst) begin
      flags_ff <= 5'h00;
      latch_ff <= 1'b0;
      boost_hold_ff <= 1'b0;
    end else begin
      flags_ff <= (flag_read ? 5'h00 : flags_ff) | flag_set;
      if (sd_evt) latch_ff <= 1'b1;
      else if (flag_read) latch_ff <= 1'b0;
      else if (ocp_sd || tsd_sd || ovp_sd) latch_ff <= 1'b1;
      if (tsd_s) boost_hold_ff <= 1'b1;
      else if (cool_s) boost_hold_ff <= 1'b0;
    end
  end
  assign rd_data =
    (index_ff == `BLCFG_REG_REV) ? {4'h0, REV_CODE} :
    (index_ff == `BLCFG_REG_EN) ? {4'h0, en_ff} :
    (index_ff == `BLCFG_REG_BRC) ? brc_ff :
    (index_ff == `BLCFG_REG_PWM) ? pwm_ff :
    (index_ff == `BLCFG_REG_BST) ? {1'b0, bst_ff} :
    (index_ff == `BLCFG_REG_AFH) ? afh_ff :
    (index_ff == `BLCFG_REG_AFL) ? afl_ff :
    (index_ff == `BLCFG_REG_BLSB) ? {5'h00, blsb_ff} :
    (index_ff == `BLCFG_REG_BMSB) ? bmsb_ff :
    (index_ff == `BLCFG_REG_FCTL) ? {4'h0, fctl_ff} :
    (index_ff == `BLCFG_REG_FFLG) ? {3'h0, flags_ff} : 8'h00;
  assign device_active = en_ff[0];
  assign boost_switch_en = en_ff[0] && !boost_hold_ff;
  assign string_on = en_ff[3:1];
  assign brightness_ctrl = brc_ff;
  assign pwm_ctrl = pwm_ff;
  assign boost_cfg = bst_ff;
  assign autofreq_high = afh_ff;
  assign autofreq_low = afl_ff;
  assign brightness_code = {bmsb_ff, blsb_ff};
  assign short_detect_en = fctl_ff[3];
  ////////////////////////////////////////////////////////////////////////
  property p_ocp_shut;
    @(posedge sys_clk) disable iff (sys_rst)
    (ocp_sd && !wr_strobe && !sw_rst) |=> !en_ff[0];
  endproperty
  a_ocp_shut: assert property (p_ocp_shut)
    else $error("overcurrent shutdown missed");
  property p_latch_block;
    @(posedge sys_clk) disable iff (sys_rst)
    (latch_ff && wr_en && !sw_rst) |=> !en_ff[0];
  endproperty
  a_latch_block: assert property (p_latch_block)
    else $error("re-enable accepted before flag read");
  property p_tsd_boost;
    @(posedge sys_clk) disable iff (sys_rst)
    (tsd_s && !sw_rst) |=> !boost_switch_en;
  endproperty
  a_tsd_boost: assert property (p_tsd_boost)
    else $error("boost kept switching in overtemp");
  property p_busy;
    @(posedge sys_clk) disable iff (sys_rst)
    start_cond |=> busy_ff;
  endproperty
  a_busy: assert property (p_busy)
    else $error("bus not busy after start");
  property p_srst_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    srst_ff |=> !srst_ff;
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("soft reset did not self-clear");
  property p_srst_defaults;
    @(posedge sys_clk) disable iff (sys_rst)
    srst_ff |=> (en_ff == `BLCFG_RST_EN) && (flags_ff == 5'h00);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults)
    else $error("soft reset left state");
  property p_rsvd_zero;
    @(posedge sys_clk) disable iff (sys_rst)
    (index_ff == `BLCFG_REG_FFLG) |-> rd_data[7:5] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");
  property p_ack_stable;
    @(posedge sys_clk) disable iff (sys_rst)
    (scl_s && !scl_fall && !start_cond && !stop_cond) |=>
      $stable(sda_oe_n) || $fell(scl_s);
  endproperty
  a_ack_stable: assert property (p_ack_stable)
    else $error("sda changed with scl high");
endmodule

// ---- testbench/blcfg_host_model.sv ----
`timescale 1ns/1ps
module blcfg_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // scl stands high between frames, sda left to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////
  // a quarter of the 64 ns scl period
  task automatic q();
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic start();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // sampled at the end of high, so slow target output still counts
  task automatic bit_x(input logic b, output logic r);
    q();
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                      output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(1'b1, ack_n);
  endtask
  ////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] i,
                    input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic [2:0] n;
    start();
    xfer({a, 1'b0}, r, n[0]);
    xfer(i, r, n[1]);
    xfer(d, r, n[2]);
    stop();
    ok = (n === 3'h0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] i,
                    output logic [7:0] v, output logic ok);
    logic [7:0] r;
    logic [3:0] n;
    start();
    xfer({a, 1'b0}, r, n[0]);
    xfer(i, r, n[1]);
    start();
    xfer({a, 1'b1}, r, n[2]);
    xfer(8'hFF, v, n[3]);
    stop();
    ok = (n === 4'h8);
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "blcfg_cfg.svh"
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end \
end
module testbench;
  import blcfg_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst, address_select_pin, overcurrent_limit, thermal_shutdown;
  logic thermal_cool, overvoltage_limit, string_open_evt, string_short_evt;
  logic sda_out, sda_oe_n, device_active, boost_switch_en, short_detect_en;
  logic [2:0] string_on;
  logic [7:0] brightness_ctrl, pwm_ctrl, autofreq_high, autofreq_low;
  logic [6:0] boost_cfg;
  logic [10:0] brightness_code;
  logic scl, m_low;
  wire sda_line;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  // open-drain line with pull-up
  assign sda_line = ~(m_low | (~sda_oe_n & ~sda_out));
  always #4 sys_clk = ~sys_clk;
  blcfg_top dut (.sys_clk, .sys_rst, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe_n, .address_select_pin, .overcurrent_limit,
    .thermal_shutdown, .thermal_cool, .overvoltage_limit,
    .string_open_evt, .string_short_evt, .device_active,
    .boost_switch_en, .string_on, .brightness_ctrl, .pwm_ctrl,
    .boost_cfg, .autofreq_high, .autofreq_low, .brightness_code,
    .short_detect_en);
  blcfg_host_model m (.sys_clk, .sda_line, .scl, .sda_low(m_low));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic ok;
    m.wr(`BLCFG_ADDR_LO, i, d, ok);
    `CHK("write ack", 1'b1, ok)
  endtask
  task automatic rc(input string nm, input logic [7:0] i,
                    input logic [7:0] e);
    logic ok;
    logic [7:0] v;
    m.rd(`BLCFG_ADDR_LO, i, v, ok);
    `CHK("read ack", 1'b1, ok)
    `CHK(nm, e, v)
  endtask
  ////////////////////////////////////////
  task automatic t_defaults();
    logic [7:0] ix [10] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13,
                           8'h15, 8'h18, 8'h19, 8'h1E};
    logic [7:0] ex [10] = '{8'h01, 8'h00, 8'h0F, 8'h60, 8'hF3, 8'h6F,
                           8'h00, 8'h07, 8'hFF, 8'h07};
    for (int k = 0; k < 10; k++) begin
      rc("reset value", ix[k], ex[k]);
    end
    rc("flags", 8'h1F, 8'h00);
    `CHK("code", 11'h7FF, brightness_code)
    `CHK("strings", 3'h7, string_on)
    $display("test defaults done");
  endtask
  task automatic t_rw();
    wr(8'h10, 8'h01);
    wr(8'h11, 8'hA5);
    rc("brc", 8'h11, 8'hA4);
    `CHK("brc port", 7'h52, brightness_ctrl[7:1])
    wr(8'h12, 8'h1C);
    rc("pwm", 8'h12, 8'h1C);
    wr(8'h15, 8'h3C);
    `CHK("af high", 8'h3C, autofreq_high)
    wr(8'h13, 8'hFF);
    rc("boost", 8'h13, 8'h7F);
    `CHK("boost port", 7'h7F, boost_cfg)
    wr(8'h19, 8'hA5);
    wr(8'h18, 8'hFE);
    rc("lsb", 8'h18, 8'h06);
    `CHK("code", 11'h52E, brightness_code)
    wr(8'h00, 8'h55);
    rc("rev", 8'h00, 8'h01);
    rc("unmapped", 8'h20, 8'h00);
    wr(8'h10, 8'hF5);
    rc("en", 8'h10, 8'h05);
    `CHK("strings", 3'h2, string_on)
    $display("test register access done");
  endtask
  task automatic t_nak();
    logic ok;
    m.wr(`BLCFG_ADDR_HI, 8'h11, 8'h00, ok);
    `CHK("foreign ack", 1'b0, ok)
    rc("brc kept", 8'h11, 8'hA4);
    $display("test foreign address done");
  endtask
  task automatic t_srst();
    wr(8'h01, 8'h01);
    rc("srst", 8'h01, 8'h00);
    rc("brc", 8'h11, 8'h60);
    rc("en", 8'h10, 8'h0F);
    $display("test soft reset done");
  endtask
  ////////////////////////////////////////
  task automatic t_ocp();
    wr(8'h1E, 8'h05);
    overcurrent_limit = 1'b1;
    hold(8);
    `CHK("active", 1'b0, device_active)
    overcurrent_limit = 1'b0;
    hold(8);
    wr(8'h10, 8'h01);
    `CHK("active", 1'b0, device_active)
    rc("flags", 8'h1F, 8'h02);
    wr(8'h10, 8'h01);
    `CHK("active", 1'b1, device_active)
    wr(8'h1E, 8'h07);
    overcurrent_limit = 1'b1;
    hold(8);
    `CHK("active", 1'b1, device_active)
    overcurrent_limit = 1'b0;
    hold(8);
    rc("flags", 8'h1F, 8'h02);
    $display("test overcurrent done");
  endtask
  task automatic t_tsd();
    thermal_shutdown = 1'b1;
    hold(8);
    `CHK("boost", 1'b0, boost_switch_en)
    `CHK("active", 1'b1, device_active)
    thermal_shutdown = 1'b0;
    thermal_cool = 1'b1;
    hold(8);
    `CHK("boost", 1'b1, boost_switch_en)
    thermal_cool = 1'b0;
    rc("flags", 8'h1F, 8'h04);
    wr(8'h1E, 8'h03);
    thermal_shutdown = 1'b1;
    hold(8);
    `CHK("active", 1'b0, device_active)
    thermal_shutdown = 1'b0;
    thermal_cool = 1'b1;
    hold(8);
    thermal_cool = 1'b0;
    wr(8'h10, 8'h01);
    `CHK("active", 1'b0, device_active)
    rc("flags", 8'h1F, 8'h04);
    wr(8'h10, 8'h01);
    `CHK("active", 1'b1, device_active)
    $display("test thermal done");
  endtask
  task automatic t_flt();
    logic ok;
    wr(8'h16, 8'h5A);
    `CHK("af low", 8'h5A, autofreq_low)
    `CHK("pwm port", 8'hF3, pwm_ctrl)
    string_short_evt = 1'b1;
    hold(8);
    string_short_evt = 1'b0;
    rc("flags", 8'h1F, 8'h00);
    wr(8'h1E, 8'h0E);
    `CHK("short en", 1'b1, short_detect_en)
    string_short_evt = 1'b1;
    overvoltage_limit = 1'b1;
    string_open_evt = 1'b1;
    hold(8);
    string_short_evt = 1'b0;
    overvoltage_limit = 1'b0;
    string_open_evt = 1'b0;
    hold(8);
    `CHK("active", 1'b0, device_active)
    rc("flags", 8'h1F, 8'h19);
    wr(8'h10, 8'h01);
    `CHK("active", 1'b1, device_active)
    address_select_pin = 1'b1;
    hold(8);
    m.wr(`BLCFG_ADDR_HI, 8'h11, 8'h24, ok);
    `CHK("strap ack", 1'b1, ok)
    `CHK("brc port", 8'h24, brightness_ctrl)
    address_select_pin = 1'b0;
    hold(8);
    $display("test fault options done");
  endtask
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    address_select_pin = 1'b0;
    overcurrent_limit = 1'b0;
    thermal_shutdown = 1'b0;
    thermal_cool = 1'b0;
    overvoltage_limit = 1'b0;
    string_open_evt = 1'b0;
    string_short_evt = 1'b0;
    hold(20);
    sys_rst = 1'b0;
    hold(5);
    t_defaults();
    t_rw();
    t_nak();
    t_srst();
    t_ocp();
    t_tsd();
    t_flt();
    give_verdict();
  end
  // whole run needs about 14000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
endmodule
